// file: bench/sdram_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// register side of the memory controller
module sdram_dev_model
    import sdram_init_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_valid,
    input  wire logic        i_write,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [1:0]  i_stall,
    input  wire logic        i_fault,
    output logic             o_ready,
    output logic [31:0]      o_rdata,
    output logic             o_irq,
    output logic [3:0]       o_ref_cmds
);
    logic [1:0]  wait_ff;
    logic [2:0]  mode_ff;
    logic        err_ff;
    logic [3:0]  ref_ff;
    logic [31:0] last_ff;
    logic        acc;
    assign o_ready = i_valid && (wait_ff == i_stall);
    assign acc = i_valid && o_ready;
    assign o_rdata = o_ready ? {31'h0, err_ff} : ~last_ff;
    assign o_irq = err_ff;
    assign o_ref_cmds = ref_ff;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) wait_ff <= 2'h0;
        else if (acc) wait_ff <= 2'h0;
        else if (i_valid) wait_ff <= wait_ff + 2'h1;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) mode_ff <= MODE_NORMAL;
        else if (acc && i_write && i_addr == REG_BASE + OFF_MODE) mode_ff <= i_wdata[2:0];
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) ref_ff <= 4'h0;
        else if (acc && i_write && i_addr[31:28] == 4'h2 && mode_ff == MODE_REFRESH)
            ref_ff <= ref_ff + 4'h1;
    end
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) err_ff <= 1'b0;
        else if (i_fault) err_ff <= 1'b1;
        else if (acc && !i_write && i_addr == REG_BASE + OFF_INT_STATUS) err_ff <= 1'b0;
    end
    always_ff @(posedge i_clk_sys) begin
        last_ff <= o_rdata;
    end
endmodule

// file: bench/sdram_init_host_bench.sv
`timescale 1ns/10ps
// ==========================================================
// init sequence and interrupt tests
module sdram_init_host_bench;
    import sdram_init_pkg::*;
    logic        i_clk_sys = 0, i_resetn = 0, i_start = 0, i_mobile = 0, fault = 0;
    logic [31:0] i_config_word = 0, i_lowpower_word = 0, i_memdev_word = 0, i_bus_rdata;
    logic [11:0] i_refresh_count = 0;
    logic [1:0]  i_row_code = 0, i_col_code = 0, stall = 0;
    logic        i_refresh_irq, i_bus_ready, o_bus_valid, o_bus_write;
    logic        o_busy, o_done, o_refresh_error;
    logic [31:0] o_bus_addr, o_bus_wdata, o_status_word;
    logic [3:0]  ref_cmds;
    logic [31:0] exp_a[$], exp_d[$];
    int          fail_count = 0, samples_checked = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    sdram_init_host #(.PAUSE_CYCLES(20)) i_sdram_init_host (.*);
    sdram_dev_model i_sdram_dev_model (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_valid(o_bus_valid), .i_write(o_bus_write), .i_addr(o_bus_addr),
        .i_wdata(o_bus_wdata), .i_stall(stall), .i_fault(fault), .o_ready(i_bus_ready),
        .o_rdata(i_bus_rdata), .o_irq(i_refresh_irq), .o_ref_cmds(ref_cmds));
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task push(input logic [31:0] a, input logic [31:0] d);
        exp_a.push_back(a);
        exp_d.push_back(d);
    endtask
    task cmd(input logic [2:0] code, input logic [1:0] bank);
        push(REG_BASE + OFF_MODE, {29'h0, code});
        push(SDRAM_BASE | ({30'h0, bank} << (20 + i_row_code + i_col_code)), 32'h0);
    endtask
    // ======================================================
    // expected write stream against the bus
    always @(posedge i_clk_sys) begin
        if (o_bus_valid === 1'b1 && i_bus_ready === 1'b1 && o_bus_write === 1'b1) begin
            if (exp_a.size() == 0) check(o_bus_addr, 32'hffff_ffff, "extra write");
            else begin
                check(o_bus_addr, exp_a.pop_front(), "address");
                check(o_bus_wdata, exp_d.pop_front(), "data");
            end
        end
    end
    task run_init(input logic mob, input logic [1:0] row, col, sl, input logic [7:0] tag);
        int n;
        @(negedge i_clk_sys);
        i_resetn = 0;
        repeat (16) @(negedge i_clk_sys);
        i_resetn = 1;
        i_mobile = mob;
        i_row_code = row;
        i_col_code = col;
        stall = sl;
        i_config_word = {24'hc0f1a0, tag};
        i_lowpower_word = {24'h0001d5, tag};
        i_memdev_word = {24'h0, tag};
        i_refresh_count = {4'h6, tag};
        exp_a.delete();
        exp_d.delete();
        push(REG_BASE + OFF_CONFIG, i_config_word);
        if (mob) push(REG_BASE + OFF_LOWPOWER, i_lowpower_word);
        push(REG_BASE + OFF_MEM_DEVICE, i_memdev_word);
        cmd(MODE_NOP, 2'h0);
        cmd(MODE_PRECHARGE, 2'h0);
        repeat (8) cmd(MODE_REFRESH, 2'h0);
        cmd(MODE_LOAD_MODE, BANK_MRS);
        if (mob) cmd(MODE_EXT_MODE, BANK_EMRS);
        cmd(MODE_NORMAL, 2'h0);
        push(REG_BASE + OFF_REFRESH, {20'h0, i_refresh_count});
        i_start = 1;
        @(negedge i_clk_sys);
        i_start = 0;
        check({31'h0, o_busy}, 32'h1, "busy");
        for (n = 0; n < 2000 && o_done !== 1'b1; n++) @(negedge i_clk_sys);
        check({31'h0, o_done}, 32'h1, "done");
        check({31'h0, o_busy}, 32'h0, "idle after init");
        check(32'(exp_a.size()), 32'h0, "writes left");
        check({28'h0, ref_cmds}, 32'h8, "refresh commands");
        $display("init test %0d done", tag);
    endtask
    task irq_test;
        int n;
        fault = 1;
        @(negedge i_clk_sys);
        fault = 0;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk_sys);
            #1;
            if (o_refresh_error === 1'b1) break;
        end
        check({31'h0, o_refresh_error}, 32'h1, "error pulse");
        check(o_status_word, 32'h1, "status word");
        check({31'h0, i_refresh_irq}, 32'h0, "flag cleared");
        check({31'h0, o_busy}, 32'h0, "idle after read");
        $display("interrupt test done");
    endtask
    initial begin
        run_init(1'b0, 2'h0, 2'h0, 2'h0, 8'h01);
        run_init(1'b1, 2'h1, 2'h1, 2'h2, 8'h02);
        run_init(1'b0, 2'h2, 2'h3, 2'h1, 8'h03);
        run_init(1'b1, 2'h1, 2'h2, 2'h3, 8'h04);
        irq_test();
        finish_test();
    end
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule

// file: bench/sdram_init_host_monitor.sv
`timescale 1ns/10ps
// ==========================================================
// port checks for the init host
module sdram_init_host_monitor
    import sdram_init_pkg::*;
#(
    parameter int PAUSE_CYCLES = PAUSE_CYC
)(
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_start,
    input wire logic [31:0] i_config_word,
    input wire logic [11:0] i_refresh_count,
    input wire logic        i_refresh_irq,
    input wire logic        i_bus_ready,
    input wire logic        o_bus_valid,
    input wire logic        o_bus_write,
    input wire logic [31:0] o_bus_addr,
    input wire logic [31:0] o_bus_wdata,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_refresh_error
);
    logic acc;
    logic mode_wr;
    logic ref_acc;
    logic sts_acc;
    logic [31:0] gap_ff;
    assign acc = o_bus_valid && i_bus_ready;
    assign mode_wr = acc && o_bus_write && o_bus_addr == REG_BASE + OFF_MODE;
    assign ref_acc = acc && o_bus_addr == REG_BASE + OFF_REFRESH;
    assign sts_acc = acc && !o_bus_write && o_bus_addr == REG_BASE + OFF_INT_STATUS;
    // idle cycles since the last request
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) gap_ff <= 32'h0;
        else if (o_bus_valid) gap_ff <= 32'h0;
        else gap_ff <= gap_ff + 32'h1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    property p_cfg;
        i_start && !o_busy && !o_done |=> o_bus_valid && o_bus_write
            && o_bus_addr == REG_BASE + OFF_CONFIG && o_bus_wdata == $past(i_config_word);
    endproperty
    a_cfg: assert property (p_cfg)
        else $error("config write not first");
    property p_hold;
        o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_addr)
            && $stable(o_bus_wdata) && $stable(o_bus_write);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request changed before accept");
    property p_pause;
        acc && o_bus_write && o_bus_addr == REG_BASE + OFF_MEM_DEVICE |=> !o_bus_valid [*8];
    endproperty
    a_pause: assert property (p_pause)
        else $error("no pause after device type");
    property p_gap;
        $rose(o_bus_valid) && o_bus_addr == REG_BASE + OFF_MODE
            && o_bus_wdata == {29'h0, MODE_NOP} |-> gap_ff >= 32'(PAUSE_CYCLES);
    endproperty
    a_gap: assert property (p_gap)
        else $error("pause shorter than set");
    property p_pair;
        mode_wr |=> o_bus_valid && o_bus_write && o_bus_wdata == 32'h0
            && o_bus_addr[31:28] == SDRAM_BASE[31:28];
    endproperty
    a_pair: assert property (p_pair)
        else $error("mode write not followed by memory write");
    property p_bit0;
        o_bus_valid && o_bus_addr[31:28] == SDRAM_BASE[31:28] |-> !o_bus_addr[0] && o_bus_write;
    endproperty
    a_bit0: assert property (p_bit0)
        else $error("byte select set in memory write");
    property p_mrs;
        mode_wr && o_bus_wdata == {29'h0, MODE_LOAD_MODE} |=> o_bus_addr == SDRAM_BASE;
    endproperty
    a_mrs: assert property (p_mrs)
        else $error("mode set not at bank zero");
    property p_emrs;
        mode_wr && o_bus_wdata == {29'h0, MODE_EXT_MODE} |=> o_bus_addr != SDRAM_BASE;
    endproperty
    a_emrs: assert property (p_emrs)
        else $error("extended mode set without bank bit");
    property p_refresh;
        o_bus_valid && o_bus_addr == REG_BASE + OFF_REFRESH
            |-> o_bus_write && o_bus_wdata == {20'h0, i_refresh_count};
    endproperty
    a_refresh: assert property (p_refresh)
        else $error("refresh count write wrong");
    property p_done;
        $rose(o_done) |-> $past(ref_acc);
    endproperty
    a_done: assert property (p_done)
        else $error("done without refresh write");
    property p_irq;
        $rose(i_refresh_irq) && o_done && !o_busy |-> ##[1:8] (o_bus_valid && !o_bus_write
            && o_bus_addr == REG_BASE + OFF_INT_STATUS);
    endproperty
    a_irq: assert property (p_irq)
        else $error("no status read after interrupt");
    property p_err;
        sts_acc |=> o_refresh_error ##1 !o_refresh_error;
    endproperty
    a_err: assert property (p_err)
        else $error("error pulse wrong");
endmodule

bind sdram_init_host sdram_init_host_monitor #(.PAUSE_CYCLES(PAUSE_CYCLES)) i_monitor (.*);

// file: hdl/sdram_addr_compose.sv
`timescale 1ns/10ps
module sdram_addr_compose
    import sdram_init_pkg::*;
(
    input  wire logic [31:0]      i_base,
    input  wire logic [1:0]       i_bank_field,
    input  wire logic [ROW_W-1:0] i_row,
    input  wire logic [COL_W-1:0] i_col,
    input  wire logic             i_halfword_byte_select,
    input  wire logic [1:0]       i_row_code,
    input  wire logic [1:0]       i_col_code,
    output logic      [31:0]      o_addr
);
    // ==========================================================
    // field placement for a 16-bit data bus
    logic [4:0]  col_bits;
    logic [4:0]  row_bits;
    logic [31:0] col_part;
    logic [31:0] row_part;
    logic [31:0] bank_part;

    always_comb begin
        col_bits  = 5'(COL_MIN_BITS) + {3'h0, i_col_code};
        row_bits  = 5'(ROW_MIN_BITS) + {3'h0, i_row_code};
        col_part  = (32'(i_col) & ((32'h1 << col_bits) - 32'h1)) << COL_LSB;
        row_part  = (32'(i_row) & ((32'h1 << row_bits) - 32'h1))
                    << (32'(COL_LSB) + 32'(col_bits));
        // bank bit 1 lands above bank bit 0
        bank_part = 32'(i_bank_field)
                    << (32'(COL_LSB) + 32'(col_bits) + 32'(row_bits));
        o_addr    = i_base | bank_part | row_part | col_part
                    | {31'h0, i_halfword_byte_select};
    end
endmodule

// file: hdl/sdram_init_host.sv
`timescale 1ns/10ps
module sdram_init_host
    import sdram_init_pkg::*;
#(
    parameter int PAUSE_CYCLES = PAUSE_CYC
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_start,
    input  wire logic [31:0] i_config_word,
    input  wire logic [31:0] i_lowpower_word,
    input  wire logic [31:0] i_memdev_word,
    input  wire logic        i_mobile,
    input  wire logic [11:0] i_refresh_count,
    input  wire logic [1:0]  i_row_code,
    input  wire logic [1:0]  i_col_code,
    input  wire logic        i_refresh_irq,
    input  wire logic        i_bus_ready,
    input  wire logic [31:0] i_bus_rdata,
    output logic             o_bus_valid,
    output logic             o_bus_write,
    output logic [31:0]      o_bus_addr,
    output logic [31:0]      o_bus_wdata,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_refresh_error,
    output logic [31:0]      o_status_word
);
    import sdram_init_pkg::*;

    state_type   state_ff;
    state_type   nxt_state;
    logic [3:0]  step_ff;
    logic [3:0]  nxt_step;
    logic        mobile_ff;
    logic        valid_ff;
    logic        nxt_valid;
    logic        write_ff;
    logic        nxt_write;
    logic [31:0] addr_ff;
    logic [31:0] nxt_addr;
    logic [31:0] wdata_ff;
    logic [31:0] nxt_wdata;
    logic [31:0] pause_ff;
    logic        pause_done;
    logic        irq_meta_ff;
    logic        irq_sync_ff;
    logic        irq_prev_ff;
    logic        irq_rise;
    logic        irq_pend_ff;
    logic        done_ff;
    logic        err_ff;
    logic [31:0] status_ff;
    logic        busy_ff;
    logic [1:0]  step_bank;
    logic [31:0] step_mem_addr;
    logic        accepted;

    // ==========================================================
    // helpers
    function automatic logic [2:0] step_mode(input logic [3:0] step);
        if (step == STEP_NOP)
            step_mode = MODE_NOP;
        else if (step == STEP_PRE)
            step_mode = MODE_PRECHARGE;
        else if (step <= STEP_REF_LAST)
            step_mode = MODE_REFRESH;
        else if (step == STEP_MRS)
            step_mode = MODE_LOAD_MODE;
        else if (step == STEP_EMRS)
            step_mode = MODE_EXT_MODE;
        else
            step_mode = MODE_NORMAL;
    endfunction

    function automatic logic [31:0] reg_addr(input logic [31:0] off);
        reg_addr = REG_BASE + off;
    endfunction

    // ==========================================================
    // address of the command write for this step
    always_comb begin
        if (step_ff == STEP_EMRS)
            step_bank = BANK_EMRS;
        else
            step_bank = BANK_MRS;
    end

    sdram_addr_compose u_compose (
        .i_base                 (SDRAM_BASE),
        .i_bank_field           (step_bank),
        .i_row                  ('0),
        .i_col                  ('0),
        .i_halfword_byte_select (1'b0),
        .i_row_code             (i_row_code),
        .i_col_code             (i_col_code),
        .o_addr                 (step_mem_addr)
    );

    // ==========================================================
    // interrupt pin synchroniser
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_meta_ff <= 1'b0;
            irq_sync_ff <= 1'b0;
            irq_prev_ff <= 1'b0;
        end else begin
            irq_meta_ff <= i_refresh_irq;
            irq_sync_ff <= irq_meta_ff;
            irq_prev_ff <= irq_sync_ff;
        end
    end

    assign irq_rise = irq_sync_ff && !irq_prev_ff;
    assign accepted = valid_ff && i_bus_ready;

    // pending interrupt: a new rise wins over the clear by the status read
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            irq_pend_ff <= 1'b0;
        else if (irq_rise)
            irq_pend_ff <= 1'b1;
        else if (state_ff == ST_STATUS && accepted)
            irq_pend_ff <= 1'b0;
    end

    // ==========================================================
    // power-up pause counter
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            pause_ff <= 32'h0;
        else if (state_ff == ST_PAUSE)
            pause_ff <= pause_ff + 32'h1;
        else
            pause_ff <= 32'h0;
    end

    assign pause_done = (pause_ff >= 32'(PAUSE_CYCLES - 1));

    // ==========================================================
    // sequence control
    always_comb begin
        nxt_state = state_ff;
        nxt_step  = step_ff;
        nxt_valid = valid_ff && !i_bus_ready;
        nxt_write = write_ff;
        nxt_addr  = addr_ff;
        nxt_wdata = wdata_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (i_start) begin
                    nxt_state = ST_CONFIG;
                    nxt_valid = 1'b1;
                    nxt_write = 1'b1;
                    nxt_addr  = reg_addr(OFF_CONFIG);
                    nxt_wdata = i_config_word;
                end
            end
            ST_CONFIG: begin
                if (accepted) begin
                    nxt_valid = 1'b1;
                    if (mobile_ff) begin
                        nxt_state = ST_LOWPOWER;
                        nxt_addr  = reg_addr(OFF_LOWPOWER);
                        nxt_wdata = i_lowpower_word;
                    end else begin
                        nxt_state = ST_MEMDEV;
                        nxt_addr  = reg_addr(OFF_MEM_DEVICE);
                        nxt_wdata = i_memdev_word;
                    end
                end
            end
            ST_LOWPOWER: begin
                if (accepted) begin
                    nxt_state = ST_MEMDEV;
                    nxt_valid = 1'b1;
                    nxt_addr  = reg_addr(OFF_MEM_DEVICE);
                    nxt_wdata = i_memdev_word;
                end
            end
            ST_MEMDEV: begin
                if (accepted)
                    nxt_state = ST_PAUSE;
            end
            ST_PAUSE: begin
                if (pause_done) begin
                    nxt_state = ST_MODE;
                    nxt_step  = STEP_NOP;
                    nxt_valid = 1'b1;
                    nxt_addr  = reg_addr(OFF_MODE);
                    nxt_wdata = {29'h0, step_mode(STEP_NOP)};
                end
            end
            ST_MODE: begin
                if (accepted) begin
                    nxt_state = ST_MEMWR;
                    nxt_valid = 1'b1;
                    nxt_addr  = step_mem_addr;
                    nxt_wdata = 32'h0;
                end
            end
            ST_MEMWR: begin
                if (accepted) begin
                    nxt_valid = 1'b1;
                    if (step_ff == STEP_NORMAL) begin
                        nxt_state = ST_REFRESH;
                        nxt_addr  = reg_addr(OFF_REFRESH);
                        nxt_wdata = {20'h0, i_refresh_count};
                    end else begin
                        nxt_state = ST_MODE;
                        if (step_ff == STEP_MRS && !mobile_ff)
                            nxt_step = STEP_NORMAL;
                        else
                            nxt_step = step_ff + 4'h1;
                        nxt_addr  = reg_addr(OFF_MODE);
                        nxt_wdata = {29'h0, step_mode(nxt_step)};
                    end
                end
            end
            ST_REFRESH: begin
                if (accepted)
                    nxt_state = ST_READY;
            end
            ST_READY: begin
                if (irq_pend_ff) begin
                    nxt_state = ST_STATUS;
                    nxt_valid = 1'b1;
                    nxt_write = 1'b0;
                    nxt_addr  = reg_addr(OFF_INT_STATUS);
                    nxt_wdata = 32'h0;
                end
            end
            ST_STATUS: begin
                if (accepted) begin
                    nxt_state = ST_READY;
                    nxt_write = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_IDLE;
            step_ff  <= STEP_NOP;
            valid_ff <= 1'b0;
            write_ff <= 1'b1;
            addr_ff  <= 32'h0;
            wdata_ff <= 32'h0;
        end else begin
            state_ff <= nxt_state;
            step_ff  <= nxt_step;
            valid_ff <= nxt_valid;
            write_ff <= nxt_write;
            addr_ff  <= nxt_addr;
            wdata_ff <= nxt_wdata;
        end
    end

    // mobile option captured at start
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            mobile_ff <= 1'b0;
        else if (state_ff == ST_IDLE && i_start)
            mobile_ff <= i_mobile;
    end

    // busy while the sequence or a status read runs
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn)
            busy_ff <= 1'b0;
        else
            busy_ff <= (nxt_state != ST_IDLE) && (nxt_state != ST_READY);
    end

    // ==========================================================
    // completion and refresh-error reporting
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            done_ff   <= 1'b0;
            err_ff    <= 1'b0;
            status_ff <= 32'h0;
        end else begin
            done_ff <= (state_ff == ST_REFRESH && accepted) ? 1'b1 : (done_ff && !i_start);
            err_ff  <= 1'b0;
            if (state_ff == ST_STATUS && accepted) begin
                status_ff <= i_bus_rdata;
                err_ff    <= 1'b1;
            end
        end
    end

    assign o_bus_valid     = valid_ff;
    assign o_bus_write     = write_ff;
    assign o_bus_addr      = addr_ff;
    assign o_bus_wdata     = wdata_ff;
    assign o_busy          = busy_ff;
    assign o_done          = done_ff;
    assign o_refresh_error = err_ff;
    assign o_status_word   = status_ff;
endmodule

// file: hdl/sdram_init_pkg.sv
package sdram_init_pkg;
    // ==========================================================
    // device register map (byte offsets from register base)
    localparam logic [31:0] REG_BASE       = 32'hffff_ea00;
    localparam logic [31:0] OFF_MODE       = 32'h0000_0000;
    localparam logic [31:0] OFF_REFRESH    = 32'h0000_0004;
    localparam logic [31:0] OFF_CONFIG     = 32'h0000_0008;
    localparam logic [31:0] OFF_LOWPOWER   = 32'h0000_0010;
    localparam logic [31:0] OFF_INT_STATUS = 32'h0000_0020;
    localparam logic [31:0] OFF_MEM_DEVICE = 32'h0000_0024;
    localparam logic [31:0] SDRAM_BASE     = 32'h2000_0000;
    // ==========================================================
    // command-mode field codes
    localparam logic [2:0]  MODE_NORMAL    = 3'h0;
    localparam logic [2:0]  MODE_NOP       = 3'h1;
    localparam logic [2:0]  MODE_PRECHARGE = 3'h2;
    localparam logic [2:0]  MODE_LOAD_MODE = 3'h3;
    localparam logic [2:0]  MODE_REFRESH   = 3'h4;
    localparam logic [2:0]  MODE_EXT_MODE  = 3'h5;
    // ==========================================================
    // init step numbering
    localparam logic [3:0]  STEP_NOP       = 4'h0;
    localparam logic [3:0]  STEP_PRE       = 4'h1;
    localparam logic [3:0]  STEP_REF_FIRST = 4'h2;
    localparam logic [3:0]  STEP_REF_LAST  = 4'h9;
    localparam logic [3:0]  STEP_MRS       = 4'ha;
    localparam logic [3:0]  STEP_EMRS      = 4'hb;
    localparam logic [3:0]  STEP_NORMAL    = 4'hc;
    localparam logic [1:0]  BANK_MRS       = 2'h0;
    localparam logic [1:0]  BANK_EMRS      = 2'h2;
    // ==========================================================
    // geometry
    localparam int          COL_MIN_BITS   = 8;
    localparam int          ROW_MIN_BITS   = 11;
    localparam int          COL_LSB        = 1;
    localparam int          ROW_W          = 13;
    localparam int          COL_W          = 11;
    // ==========================================================
    // timing
    localparam int          CLK_MHZ        = 100;
    localparam int          PAUSE_US       = 200;
    localparam int          PAUSE_CYC      = PAUSE_US * CLK_MHZ;
    localparam logic [11:0] REFRESH_DFLT   = 12'h61a;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CONFIG, ST_LOWPOWER, ST_MEMDEV, ST_PAUSE,
        ST_MODE, ST_MEMWR, ST_REFRESH, ST_READY, ST_STATUS
    } state_type;
endpackage
